// [rtl/irb_pkg.sv]
package irb_pkg;

  // ====================================================================
  // register map (apb byte addresses, one word each)
  // ====================================================================
  localparam logic [7:0] ADDR_HOLD = 8'h00;
  localparam logic [7:0] ADDR_RESID = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_SHIFT = 8'h14;

  // ====================================================================
  // fields and reset values
  // ====================================================================
  localparam int CTRL_EN_BIT = 0;
  localparam int EV_FULL_BIT = 0;
  localparam int EV_END_BIT = 1;
  localparam int EV_ERR_BIT = 2;
  localparam int EV_NUM = 3;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [2:0] RESID_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ====================================================================
  // carriers
  // ====================================================================
  typedef struct packed {
    logic bit_valid;
    logic bit_value;
    logic frame_end;
    logic rx_error;
  } irb_rx_t;

  typedef struct packed {
    logic err;
    logic fend;
    logic full;
  } irb_ev_t;

  typedef enum logic [1:0] {
    IRB_IDLE = 2'b00,
    IRB_RECV = 2'b01,
    IRB_ENDED = 2'b10
  } irb_state_t;

endpackage : irb_pkg

// [rtl/irb_shift.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// shift register, residual counter and holding register
// ======================================================================
module irb_shift #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic err,
  input wire logic clr_resid,
  output logic [WIDTH-1:0] shift_reg,
  output logic [WIDTH-1:0] hold_reg,
  output logic [$clog2(WIDTH)-1:0] resid,
  output logic full_pulse
);

  localparam int CW = $clog2(WIDTH);
  localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

  initial begin
    if (WIDTH != 8) $error("irb_shift: only 8-bit bytes are supported");
  end

  logic wrap;
  logic [WIDTH-1:0] next_shift;
  assign wrap = bit_valid && (resid == LAST);
  // newest bit enters at the top so the first bit ends in bit 0
  assign next_shift = {bit_value, shift_reg[WIDTH-1:1]};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else if (!enable) begin
      shift_reg <= '0;
    end else if (wrap) begin
      shift_reg <= '0;
    end else if (bit_valid) begin
      shift_reg <= next_shift;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_reg <= '0;
    end else if (!enable) begin
      hold_reg <= '0;
    end else if (wrap) begin
      // no guard against an unread byte
      hold_reg <= next_shift;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_pulse <= 1'b0;
    end else begin
      full_pulse <= enable && wrap;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resid <= '0;
    end else if (!enable || err || clr_resid) begin
      resid <= '0;
    end else if (bit_valid) begin
      resid <= resid + CW'(1);
    end
  end

endmodule : irb_shift

`default_nettype wire

// [rtl/irb_irq.sv]
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// sticky event flags, mask, level interrupt
// ======================================================================
module irb_irq #(
  parameter int N = 3
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [N-1:0] ev_set,
  input wire logic rd_clear,
  input wire logic [N-1:0] mask,
  output logic [N-1:0] pending,
  output logic irq
);

  initial begin
    if (N < 1) $error("irb_irq: need at least one event");
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pending[i] <= 1'b0;
        end else if (ev_set[i]) begin
          // set beats a clearing read in the same cycle
          pending[i] <= 1'b1;
        end else if (rd_clear) begin
          pending[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      // clear must cover every flag, not only bit 0
      irq <= |(((pending & ~{N{rd_clear}}) | ev_set) & mask);
    end
  end

endmodule : irb_irq

`default_nettype wire

// [rtl/irb_top.sv]
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - when eight bits have been shifted in, the shift register contents are copied to the holding register.
// - the first received bit of a byte lands in bit 0 of the holding register and the last in bit 7.
// - byte_full_event fires in the same cycle as the copy into the holding register, unless rx_error comes with the eighth bit; the full flag is set anyway.
// - reset clears the holding register to zero.
// - while the receiver is disabled the holding register is held at zero.
// - a new full byte overwrites an unread one without protection.
// - a 3-bit residual counter counts received bits and wraps to zero after eight.
// - the residual counter lets software learn the trailing bit count of frames that are not whole bytes.
// - reset clears the residual counter to zero.
// - the residual counter clears on disable, on a receive error, or on a shift register read after frame end.
// - holding register (8 bits) and residual counter (3 bits) are read-only registers.
// - each event sets a pending flag that the acknowledge (a status read) or reset clears.
module irb_top #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic frame_end,
  input wire logic rx_error,
  output logic receiver_enable_bit,
  output logic byte_full_event,
  output logic frame_end_event,
  output logic receive_error_event,
  output logic irq
);

  initial begin
    if (WIDTH != 8) $error("irb_top: WIDTH must be 8");
  end

  // ====================================================================
  // decode helpers
  // ====================================================================
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      irb_pkg::ADDR_HOLD, irb_pkg::ADDR_RESID, irb_pkg::ADDR_CTRL,
      irb_pkg::ADDR_STATUS, irb_pkg::ADDR_MASK, irb_pkg::ADDR_SHIFT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic is_ro(input logic [7:0] a);
    is_ro = (a != irb_pkg::ADDR_CTRL) && (a != irb_pkg::ADDR_MASK);
  endfunction : is_ro

  // ====================================================================
  // bus side
  // ====================================================================
  irb_pkg::irb_rx_t rx;
  assign rx = '{bit_valid: bit_valid, bit_value: bit_value, frame_end: frame_end, rx_error: rx_error};

  logic access;
  logic wr_ok;
  logic rd_hit;
  logic [2:0] mask;
  logic [2:0] pending;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] hold_reg;
  logic [2:0] resid;
  logic full_pulse;
  irb_pkg::irb_state_t state;
  irb_pkg::irb_ev_t ev;

  // one wait state: answer on the second access cycle
  assign access = psel && penable && pready;
  // writes with pstrb[0] low and writes to read-only words are refused
  assign wr_ok = access && pwrite && is_mapped(paddr) && !is_ro(paddr) && (pstrb[0] == 1'b1);
  assign rd_hit = access && !pwrite;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= !is_mapped(paddr) || (pwrite && (is_ro(paddr) || !pstrb[0]));
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && penable && !pready && !pwrite) begin
      case (paddr)
        irb_pkg::ADDR_HOLD: prdata <= {24'h000000, hold_reg};
        irb_pkg::ADDR_RESID: prdata <= {29'h00000000, resid};
        irb_pkg::ADDR_CTRL: prdata <= {31'h00000000, receiver_enable_bit};
        irb_pkg::ADDR_STATUS: prdata <= {29'h00000000, pending};
        irb_pkg::ADDR_MASK: prdata <= {29'h00000000, mask};
        irb_pkg::ADDR_SHIFT: prdata <= {24'h000000, shift_reg};
        default: prdata <= '0;
      endcase
    end else if (!psel) begin
      prdata <= '0;
    end
  end

  // ====================================================================
  // control registers
  // ====================================================================
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      receiver_enable_bit <= 1'b0;
    end else if (wr_ok && paddr == irb_pkg::ADDR_CTRL) begin
      receiver_enable_bit <= pwdata[irb_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= irb_pkg::MASK_RESET;
    end else if (wr_ok && paddr == irb_pkg::ADDR_MASK) begin
      mask <= pwdata[2:0];
    end
  end

  // ====================================================================
  // frame tracking: a shift read counts only after frame end
  // ====================================================================
  logic shift_read;
  assign shift_read = rd_hit && (paddr == irb_pkg::ADDR_SHIFT);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= irb_pkg::IRB_IDLE;
    end else if (!receiver_enable_bit) begin
      state <= irb_pkg::IRB_IDLE;
    end else begin
      case (state)
        irb_pkg::IRB_IDLE: begin
          if (rx.bit_valid) state <= irb_pkg::IRB_RECV;
        end
        irb_pkg::IRB_RECV: begin
          if (rx.rx_error) state <= irb_pkg::IRB_IDLE;
          else if (rx.frame_end) state <= irb_pkg::IRB_ENDED;
        end
        irb_pkg::IRB_ENDED: begin
          if (shift_read || rx.rx_error) state <= irb_pkg::IRB_IDLE;
          else if (rx.bit_valid) state <= irb_pkg::IRB_RECV;
        end
        default: state <= irb_pkg::IRB_IDLE;
      endcase
    end
  end

  logic clr_resid;
  // software is expected to fetch the count before the shift read
  assign clr_resid = shift_read && (state == irb_pkg::IRB_ENDED);

  // ====================================================================
  // datapath and events
  // ====================================================================
  irb_shift #(
    .WIDTH(WIDTH)
  ) u_shift (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .enable(receiver_enable_bit),
    .bit_valid(rx.bit_valid),
    .bit_value(rx.bit_value),
    .err(rx.rx_error),
    .clr_resid(clr_resid),
    .shift_reg(shift_reg),
    .hold_reg(hold_reg),
    .resid(resid),
    .full_pulse(full_pulse)
  );

  assign ev = '{err: receiver_enable_bit && rx.rx_error,
                fend: receiver_enable_bit && rx.frame_end,
                full: full_pulse};

  // full pulse already registered; align the other two to it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_full_event <= 1'b0;
      frame_end_event <= 1'b0;
      receive_error_event <= 1'b0;
    end else begin
      byte_full_event <= receiver_enable_bit && rx.bit_valid && (resid == 3'h7) && !rx.rx_error;
      frame_end_event <= ev.fend;
      receive_error_event <= ev.err;
    end
  end

  logic status_read;
  assign status_read = rd_hit && (paddr == irb_pkg::ADDR_STATUS);

  irb_irq #(
    .N(irb_pkg::EV_NUM)
  ) u_irq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ev_set({ev.err, ev.fend, ev.full}),
    .rd_clear(status_read),
    .mask(mask),
    .pending(pending),
    .irq(irq)
  );

endmodule : irb_top

`default_nettype wire

// [bench/irb_checker.sv]
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// port-level checks
// ====================================================================
module irb_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_valid,
  input wire logic frame_end,
  input wire logic rx_error,
  input wire logic receiver_enable_bit,
  input wire logic byte_full_event,
  input wire logic frame_end_event,
  input wire logic receive_error_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic rd_ok;
  assign rd_ok = pready && !pwrite;
  // exactly one wait state, never more
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  property p_apb;
    psel && !penable |=> s_wait;
  endproperty
  a_apb: assert property (p_apb) else $error("wrong apb wait");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready stuck");
  property p_slv;
    pslverr |-> pready;
  endproperty
  a_slv: assert property (p_slv) else $error("stray pslverr");
  property p_ro;
    pready && pwrite && (paddr == irb_pkg::ADDR_HOLD || paddr == irb_pkg::ADDR_RESID) |-> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("ro write accepted");
  property p_res;
    rd_ok && paddr == irb_pkg::ADDR_RESID |-> prdata[31:3] == 29'h0;
  endproperty
  a_res: assert property (p_res) else $error("count too wide");
  property p_hold0;
    rd_ok && paddr == irb_pkg::ADDR_HOLD && !receiver_enable_bit |-> prdata == 32'h0;
  endproperty
  a_hold0: assert property (p_hold0) else $error("hold not clear");
  property p_full;
    byte_full_event |-> $past(bit_valid) && $past(receiver_enable_bit);
  endproperty
  a_full: assert property (p_full) else $error("full without bit");
  property p_fend;
    frame_end && receiver_enable_bit |=> frame_end_event;
  endproperty
  a_fend: assert property (p_fend) else $error("no end event");
  property p_err;
    rx_error && receiver_enable_bit |=> receive_error_event;
  endproperty
  a_err: assert property (p_err) else $error("no error event");
  property p_off;
    !receiver_enable_bit |=> !byte_full_event && !frame_end_event && !receive_error_event;
  endproperty
  a_off: assert property (p_off) else $error("event while off");
endmodule : irb_checker

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// bench
// ====================================================================
module tb_top;
  logic sys_clk, sys_rst, psel, penable, pwrite, bit_valid, bit_value, frame_end, rx_error;
  logic pready, pslverr, en, bfe, fee, ree, irq, e, on;
  logic [3:0] pstrb;
  logic [7:0] paddr, d;
  logic [31:0] pwdata, prdata, r, seed;
  int miscompares, compares, k;
  irb_top uut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .bit_valid, .bit_value, .frame_end, .rx_error, .receiver_enable_bit(en),
    .byte_full_event(bfe), .frame_end_event(fee), .receive_error_event(ree), .irq);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // partial byte sits at the top, newest bit in bit 7
  function automatic logic [31:0] shx(input int n, input logic [7:0] v);
    logic [7:0] t;
    t = v << (8 - n);
    return {24'h0, t};
  endfunction : shx
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    // request stands until the edge that sees pready high
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t no pready", $time);
    end
    r = prdata;
    e = pslverr;
    if (w && a == irb_pkg::ADDR_CTRL && pstrb[0]) on = wd[irb_pkg::CTRL_EN_BIT];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic bits(input int n, input logic [7:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      bit_valid <= 1'b1;
      bit_value <= v[i];
    end
    @(posedge sys_clk);
    bit_valid <= 1'b0;
    @(posedge sys_clk);
    chk(bfe, n == 8 && on);
  endtask : bits
  task automatic pls(input logic f);
    @(posedge sys_clk);
    frame_end <= f;
    rx_error <= !f;
    @(posedge sys_clk);
    frame_end <= 1'b0;
    rx_error <= 1'b0;
    @(posedge sys_clk);
    chk(f ? fee : ree, on);
    chk(en, on);
  endtask : pls
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // ==================================================================
  // clock, watchdog, sequence
  // ==================================================================
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
  initial begin
    {sys_rst, psel, penable, pwrite, bit_valid, bit_value, frame_end, rx_error} = 8'h80;
    {paddr, pwdata} = 40'h0;
    pstrb = 4'hf;
    on = 1'b0;
    seed = 32'hd3ba;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 6; k++) rd(8'(4 * k), 32'h0);
    rd(8'h18, 32'h0);
    chk(e, 1'b1);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 8'(4 * k), 32'h5a);
      chk(e, 1'b1);
    end
    // partial-width write to the enable must be refused
    pstrb <= 4'he;
    apb(1'b1, irb_pkg::ADDR_CTRL, 32'h1);
    chk(e, 1'b1);
    pstrb <= 4'hf;
    // bits while off must leave nothing behind
    bits(8, 8'ha5);
    rd(irb_pkg::ADDR_HOLD, 32'h0);
    apb(1'b1, irb_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, irb_pkg::ADDR_MASK, 32'h7);
    repeat (4) begin
      d = 8'(xs());
      bits(8, d);
      rd(irb_pkg::ADDR_HOLD, {24'h0, d});
      rd(irb_pkg::ADDR_RESID, 32'h0);
      chk(irq, 1'b1);
      rd(irb_pkg::ADDR_STATUS, 32'h1);
      rd(irb_pkg::ADDR_STATUS, 32'h0);
      chk(irq, 1'b0);
    end
    d = 8'(xs());
    bits(8, d);
    bits(8, ~d);
    rd(irb_pkg::ADDR_HOLD, {24'h0, ~d});
    k = 1 + xs() % 7;
    d = 8'(xs());
    bits(k, d);
    pls(1'b1);
    rd(irb_pkg::ADDR_RESID, k);
    rd(irb_pkg::ADDR_SHIFT, shx(k, d));
    rd(irb_pkg::ADDR_RESID, 32'h0);
    rd(irb_pkg::ADDR_STATUS, 32'h3);
    // masked error: flag set, no interrupt
    apb(1'b1, irb_pkg::ADDR_MASK, 32'h0);
    bits(5, d);
    pls(1'b0);
    chk(irq, 1'b0);
    rd(irb_pkg::ADDR_RESID, 32'h0);
    rd(irb_pkg::ADDR_STATUS, 32'h4);
    bits(3, d);
    apb(1'b1, irb_pkg::ADDR_CTRL, 32'h0);
    rd(irb_pkg::ADDR_HOLD, 32'h0);
    rd(irb_pkg::ADDR_RESID, 32'h0);
    pls(1'b1);
    apb(1'b1, irb_pkg::ADDR_CTRL, 32'h1);
    bits(3, ~d);
    rd(irb_pkg::ADDR_RESID, 32'h3);
    rd(irb_pkg::ADDR_SHIFT, shx(3, ~d));
    close_out();
  end
endmodule : tb_top

bind irb_top irb_checker u_chk (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .bit_valid, .frame_end, .rx_error, .receiver_enable_bit, .byte_full_event, .frame_end_event,
  .receive_error_event);

`default_nettype wire
